// [hdl/scp_serial_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.svh"

// What this block does
// - Enable low powers the whole port down
// - Enable low wipes every programmed latch
// - Serial clock rise shifts data into 32 bits
// - Low four bits select destination latch
// - Load strobe rise copies word to latch
// - Readback shifts out one bit per clock
// - Test pins stay high impedance
module scp_serial_port (
  // Clock and reset
  input  wire logic                                       core_clk,
  input  wire logic                                       rst,
  // Serial pins from the host
  input  wire logic                                       chip_enable,
  input  wire logic                                       serial_clk,
  input  wire logic                                       serial_in,
  input  wire logic                                       load_strobe,
  output var  logic                                       readback_out,
  // On-chip readback source
  input  wire logic [`SCP_RB_W-1:0]                       readback_word,
  // Signal chain test pins
  input  wire logic                                       filter_i_test_pin_in,
  output var  logic                                       filter_i_test_pin_out,
  output var  logic                                       filter_i_test_pin_oe,
  input  wire logic                                       filter_q_test_pin_in,
  output var  logic                                       filter_q_test_pin_out,
  output var  logic                                       filter_q_test_pin_oe,
  // Programmed state
  output var  logic                                       powered_up,
  output var  logic [`SCP_NUM_LATCH-1:0][`SCP_WORD_W-1:0] latch_q
);

  scp_pkg::scp_top_st_t r_reg;
  scp_pkg::scp_top_st_t r_next;
  scp_rb_if             rbi ();
  logic                 active;
  logic                 sclk_rise;
  logic                 le_rise;
  logic [`SCP_CTRL_W-1:0] sel;

  // Pins come from the host's domain, so all pass two flops first
  assign active    = r_reg.ce_s2;
  assign sclk_rise = r_reg.sclk_s2 & ~r_reg.sclk_s3;
  assign le_rise   = r_reg.le_s2 & ~r_reg.le_s3;
  assign sel       = r_reg.shreg[`SCP_CTRL_W-1:0];

  always_comb begin
    r_next         = r_reg;
    r_next.ce_s1   = chip_enable;
    r_next.ce_s2   = r_reg.ce_s1;
    r_next.sclk_s1 = serial_clk;
    r_next.sclk_s2 = r_reg.sclk_s1;
    r_next.sclk_s3 = r_reg.sclk_s2;
    r_next.sd_s1   = serial_in;
    r_next.sd_s2   = r_reg.sd_s1;
    r_next.le_s1   = load_strobe;
    r_next.le_s2   = r_reg.le_s1;
    r_next.le_s3   = r_reg.le_s2;
    r_next.test_oe = 1'b0;
    unique case (r_reg.state)
      scp_pkg::ST_OFF: begin
        if (active) begin
          r_next.state = scp_pkg::ST_ON;
        end
      end
      scp_pkg::ST_ON: begin
        if (!active) begin
          r_next.state = scp_pkg::ST_OFF;
        end
      end
      // Codes that are not one-hot fall back to off
      default: begin
        r_next.state = scp_pkg::ST_OFF;
      end
    endcase
    r_next.pwr = (r_next.state == scp_pkg::ST_ON);
    if (!active) begin
      // Nothing survives power-down, so the host must reprogram
      r_next.shreg   = '0;
      r_next.latches = '0;
    end else begin
      // A load in the same cycle as a shift takes the word before the shift
      if (le_rise) begin
        r_next.latches[sel] = r_reg.shreg;
      end
      if (sclk_rise) begin
        r_next.shreg = {r_reg.shreg[`SCP_WORD_W-2:0], r_reg.sd_s2};
      end
    end
  end

  always_comb begin
    rbi.clear       = ~active;
    // The readback code still lands in its latch; arming readback is extra
    rbi.load_pulse  = active & le_rise & (sel == `SCP_RB_SEL);
    rbi.shift_pulse = active & sclk_rise;
    rbi.word        = readback_word;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg       <= '0;
      r_reg.state <= scp_pkg::ST_OFF;
    end else begin
      r_reg <= r_next;
    end
  end

  scp_readback u_readback (
    .core_clk (core_clk),
    .rst      (rst),
    .rbi      (rbi.rb)
  );

  assign readback_out          = rbi.bit_out;
  assign powered_up            = r_reg.pwr;
  assign latch_q               = r_reg.latches;
  // Pin value is a don't-care while undriven; taken from a flop like every output
  assign filter_i_test_pin_out = r_reg.test_oe;
  assign filter_q_test_pin_out = r_reg.test_oe;
  assign filter_i_test_pin_oe  = r_reg.test_oe;
  assign filter_q_test_pin_oe  = r_reg.test_oe;

  // Helpers for checks only
  logic [`SCP_CTRL_W-1:0] sel_h;
  logic [`SCP_WORD_W-1:0] word_h;
  assign sel_h  = sel;
  assign word_h = r_reg.shreg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  pd_enter_a: assert property ((!chip_enable) [*3] |=> !powered_up)
    else $error("port not powered down after enable low");
  pd_clear_a: assert property (!active |=> latch_q == '0 && r_reg.shreg == '0)
    else $error("programmed state survived power-down");
  shift_in_a: assert property (active && sclk_rise
                               |=> word_h == {$past(word_h[`SCP_WORD_W-2:0]), $past(r_reg.sd_s2)})
    else $error("serial bit not shifted in");
  ctrl_decode_a: assert property (active && le_rise |=> latch_q[$past(sel_h)] == $past(word_h))
    else $error("word not loaded into selected latch");
  load_one_a: assert property (active && le_rise && sel_h != 4'h0
                               |=> latch_q[0] == $past(latch_q[0]))
    else $error("unselected latch changed on load");
  latch_hold_a: assert property (active && !le_rise |=> latch_q == $past(latch_q))
    else $error("latch changed without load strobe");
  test_hiz_a: assert property (!filter_i_test_pin_oe && !filter_q_test_pin_oe)
    else $error("test pin driven");
  rb_arm_a: assert property (active && le_rise && sel_h == `SCP_RB_SEL
                             |=> readback_out == $past(readback_word[`SCP_RB_W-1]))
    else $error("readback not armed on readback code");

  // Power state follows the synchronised enable one cycle later
  pwr_on_a: assert property (active |=> powered_up)
    else $error("port not powered up while enabled");
  pwr_off_a: assert property (!active |=> !powered_up)
    else $error("port still powered while enable low");
  pwr_rise_a: assert property ($rose(powered_up) |-> $past(active))
    else $error("power up without synchronised enable");
  rb_off_a: assert property (!active |=> !readback_out)
    else $error("readback output active while disabled");

  // Shift register and readback hold between serial clock edges, except readback on a readback-code load
  shift_hold_a: assert property (active && !sclk_rise |=> word_h == $past(word_h))
    else $error("shift register moved without serial clock");
  rb_hold_a: assert property (active && !sclk_rise && !le_rise |=> $stable(readback_out))
    else $error("readback output moved without serial clock");
  rb_step_a: assert property (active && sclk_rise && !le_rise
                              |=> readback_out == $past(u_readback.r_reg.shreg[`SCP_RB_W-2]))
    else $error("readback output did not advance one bit");
  rb_other_a: assert property (active && le_rise && !sclk_rise && sel_h != `SCP_RB_SEL
                               |=> $stable(readback_out))
    else $error("readback armed by another control code");

  // Every latch not chosen by the code keeps its word on a load
  for (genvar i = 0; i < `SCP_NUM_LATCH; i++) begin : g_keep
    latch_keep_a: assert property (active && le_rise && sel_h != `SCP_CTRL_W'(i)
                                   |=> latch_q[i] == $past(latch_q[i]))
      else $error("unselected latch changed on load");
  end

  load_c:   cover property (active && le_rise);
  pcycle_c: cover property (powered_up ##1 !powered_up ##[1:20] powered_up);
  rbsel_c:  cover property (active && le_rise && sel_h == `SCP_RB_SEL);
  rbrd_c:   cover property (active && le_rise && sel_h == `SCP_RB_SEL ##[4:40] active && sclk_rise);

endmodule

`default_nettype wire

// [hdl/scp_map.svh]
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// Serial word and latch geometry
`define SCP_WORD_W    32
`define SCP_CTRL_W    4
`define SCP_NUM_LATCH 16
// Control code that also arms a readback
`define SCP_RB_SEL    4'hf
// Readback word width
`define SCP_RB_W      16

`endif

// [hdl/scp_pkg.sv]
`default_nettype none
`include "scp_map.svh"

package scp_pkg;

  typedef enum logic [1:0] {
    ST_OFF = 2'b01,
    ST_ON  = 2'b10
  } scp_state_t;

  typedef struct packed {
    scp_state_t                                 state;
    logic                                       pwr;
    logic                                       ce_s1;
    logic                                       ce_s2;
    logic                                       sclk_s1;
    logic                                       sclk_s2;
    logic                                       sclk_s3;
    logic                                       sd_s1;
    logic                                       sd_s2;
    logic                                       le_s1;
    logic                                       le_s2;
    logic                                       le_s3;
    logic [`SCP_WORD_W-1:0]                     shreg;
    logic [`SCP_NUM_LATCH-1:0][`SCP_WORD_W-1:0] latches;
    logic                                       test_oe;
  } scp_top_st_t;

  typedef struct packed {
    logic [`SCP_RB_W-1:0] shreg;
  } scp_rb_st_t;

endpackage

`default_nettype wire

// [hdl/scp_rb_if.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.svh"

interface scp_rb_if;
  logic                 load_pulse;
  logic                 shift_pulse;
  logic                 clear;
  logic [`SCP_RB_W-1:0] word;
  logic                 bit_out;

  modport ctrl (output load_pulse, output shift_pulse, output clear, output word, input bit_out);
  modport rb   (input load_pulse, input shift_pulse, input clear, input word, output bit_out);
endinterface

`default_nettype wire

// [hdl/scp_readback.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.svh"

module scp_readback (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control side
  scp_rb_if.rb     rbi
);

  scp_pkg::scp_rb_st_t r_reg;
  scp_pkg::scp_rb_st_t r_next;

  always_comb begin
    r_next = r_reg;
    if (rbi.clear) begin
      r_next.shreg = '0;
    end else if (rbi.load_pulse) begin
      r_next.shreg = rbi.word;
    end else if (rbi.shift_pulse) begin
      // Zero fill: reading past the word gives low bits, not stale data
      r_next.shreg = {r_reg.shreg[`SCP_RB_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rbi.bit_out = r_reg.shreg[`SCP_RB_W-1];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  rb_load_a: assert property (rbi.load_pulse && !rbi.clear |=> rbi.bit_out == $past(rbi.word[`SCP_RB_W-1]))
    else $error("readback msb not presented after load");
  rb_shift_a: assert property (rbi.shift_pulse && !rbi.load_pulse && !rbi.clear
                               |=> r_reg.shreg == {$past(r_reg.shreg[`SCP_RB_W-2:0]), 1'b0})
    else $error("readback did not advance one bit");
  rb_clear_a: assert property (rbi.clear |=> !rbi.bit_out)
    else $error("readback active during power-down");
  rb_shift_c: cover property (rbi.load_pulse ##[1:40] rbi.shift_pulse);

endmodule

`default_nettype wire

// [test/scp_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module scp_host_model (
  // Clock
  input  wire logic core_clk,
  // Serial pins
  output var  logic serial_clk,
  output var  logic serial_in,
  output var  logic load_strobe,
  input  wire logic readback_out
);
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    load_strobe = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Four cycles a level, twice the two-flop synchroniser depth
  task automatic clock_bit(input logic b);
    serial_in = b;
    wait_cyc(4);
    serial_clk = 1'b1;
    wait_cyc(4);
    serial_clk = 1'b0;
  endtask
  task automatic send_word(input logic [31:0] w, input logic load);
    for (int i = 31; i >= 0; i--) begin
      clock_bit(w[i]);
    end
    // Released data line flips so a stale bit cannot pass
    serial_in = ~w[0];
    wait_cyc(4);
    load_strobe = load;
    wait_cyc(4);
    load_strobe = 1'b0;
    wait_cyc(4);
  endtask
  task automatic read_bits(input int n, output logic [31:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      got = {got[30:0], readback_out};
      clock_bit(~serial_in);
    end
  endtask
endmodule
`default_nettype wire

// [test/serial_config_port_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.svh"
module serial_config_port_bench;
  logic                   core_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   chip_enable = 1'b1;
  logic                   sclk, sin, lstb, rb_out, fi_out, fi_oe, fq_out, fq_oe, powered_up;
  logic [`SCP_RB_W-1:0]   rb_word = 16'h0000;
  logic [15:0][31:0]      latch_q;
  logic [31:0]            exp_w [16];
  logic [31:0]            got;
  int                     n_mismatch = 0;
  int                     tests_run = 0;
  int                     cycles = 0;

  scp_serial_port DUT (.core_clk(core_clk), .rst(rst), .chip_enable(chip_enable), .serial_clk(sclk),
    .serial_in(sin), .load_strobe(lstb), .readback_out(rb_out), .readback_word(rb_word),
    .filter_i_test_pin_in(1'b0), .filter_i_test_pin_out(fi_out), .filter_i_test_pin_oe(fi_oe),
    .filter_q_test_pin_in(1'b0), .filter_q_test_pin_out(fq_out), .filter_q_test_pin_oe(fq_oe),
    .powered_up(powered_up), .latch_q(latch_q));
  scp_host_model host (.core_clk(core_clk), .serial_clk(sclk), .serial_in(sin), .load_strobe(lstb),
    .readback_out(rb_out));

  always #10 core_clk = ~core_clk;

  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Run is near 5300 cycles; the ceiling leaves ample slack
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask

  task automatic t_latches();
    for (int n = 0; n < 16; n++) begin
      exp_w[n] = {4'(15 - n), 24'hc3_5a96 ^ 24'(n * 24'h11_1111), 4'(n)};
      host.send_word(exp_w[n], 1'b1);
      chk_word(latch_q[n], exp_w[n]);
    end
    for (int n = 0; n < 16; n++) chk_word(latch_q[n], exp_w[n]);
  endtask

  task automatic t_no_load();
    host.send_word(32'h1234_5675, 1'b0);
    chk_word(latch_q[5], exp_w[5]);
  endtask

  task automatic t_readback();
    rb_word = 16'ha5c3;
    host.send_word(32'h0000_beef, 1'b1);
    chk_word(latch_q[15], 32'h0000_beef);
    host.read_bits(17, got);
    chk_word(got, 32'h0001_4b86);
  endtask

  task automatic t_power();
    chip_enable = 1'b0;
    host.wait_cyc(6);
    chk_flag(powered_up, 1'b0);
    chk_flag(rb_out, 1'b0);
    for (int n = 0; n < 16; n++) chk_word(latch_q[n], 32'h0000_0000);
    chk_flag(fi_oe | fq_oe, 1'b0);
    chk_flag(fi_out | fq_out, 1'b0);
    chip_enable = 1'b1;
    host.wait_cyc(6);
    chk_flag(powered_up, 1'b1);
    chk_word(latch_q[3], 32'h0000_0000);
    host.send_word(32'h8765_4323, 1'b1);
    chk_word(latch_q[3], 32'h8765_4323);
    chk_flag(fi_oe | fq_oe, 1'b0);
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    host.wait_cyc(6);
    chk_flag(powered_up, 1'b1);
    t_latches();
    t_no_load();
    t_readback();
    t_power();
    finish_test();
  end
endmodule
`default_nettype wire
